// >>> core/bmsl_loader.sv
`timescale 1ns/1ns
// Functional notes
// - cfg bits 11 start user mode, user flash mapped at address zero.
// - cfg 10 standard bootstrap: flash from zero, code fetches at zero go to test flash.
// - cfg 01 alternate boot, mapping from signature check; 00 is reserved.
// - alternate boot jumps to address 09'0000h.
// - user code path pulses software reset and sets start at zero in the same cycle.
// - selective bootstrap jumps into test flash then checks the channel.
// - boot_cfg_lo low at reset end enters bootstrap whatever the bus mode.
// - bootstrap scans serial for start bit and can for valid dominant bit.
// - after can falling edge serial wins until the next raw can rising edge.
// - can pulses shorter than 20 cpu cycles are rejected.
// - watchdog held disabled in bootstrap mode.
// - bootstrap loads pointers FA00, FA40, limits FC00 and FA00.
// - system config becomes 0404, ext periph enable only for can or alternate.
// - serial boot sets control 8011, baud from zero byte, drives tx high.
// - can boot clears can status, timing from zero frame, periph 042D, tx high.
// - bootstrap always sets internal mem enable bit 10; bit 9 from bus width.
// - bus control zero cleared if external access high, else bits 10, 9 and type.
// - bootstrap blocks code execution from internal user flash.
// - loader stores bytes in internal ram, runs after preset byte count.
// - boot cfg bits latched on rising edge of reset input pin.
// - alternate: user signature wins, then alternate signature, else user key.
module bmsl_loader
  import bmsl_pkg::*;
#(
  parameter int RAM_DEPTH = 256
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        reset_input_pin,
  input  wire logic        boot_cfg_lo,
  input  wire logic        boot_cfg_hi,
  input  wire logic        external_access_pin,
  input  wire logic        bus_width_8,
  input  wire logic [1:0]  bus_type_cfg,
  input  wire logic        user_sig_ok,
  input  wire logic        alt_sig_ok,
  input  wire logic        user_key_alt,
  input  wire logic        serial_rx_line,
  input  wire logic        can_rx_line,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        baud_valid,
  input  wire logic [15:0] baud_value,
  input  wire logic        can_timing_valid,
  input  wire logic [15:0] can_timing_value,
  input  wire logic        fetch_valid,
  input  wire logic        fetch_from_flash,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             serial_tx_line,
  output logic             serial_tx_oe,
  output logic             can_tx_line,
  output logic             can_tx_oe,
  output logic             watchdog_disable,
  output logic             bootstrap_mode,
  output logic             soft_reset,
  output logic             test_flash_fetch,
  output logic             flash_fetch_block,
  output logic [23:0]      start_addr,
  output logic             start_valid,
  output logic             cfg_reserved
);

  bmsl_state_t state;
  bmsl_chan_t  chan;
  logic [1:0]  cfg;
  logic        ext_acc;
  logic        bw8;
  logic [1:0]  bus_type_field;
  logic        rst_pin_d;
  logic        latched;
  logic        ser_d;
  logic        can_filt;
  logic        can_raw_d;
  logic [4:0]  can_cnt;
  logic        can_prio_ser;
  logic        can_fall_seen;
  logic [15:0] system_config_reg;
  logic [15:0] bus_control_zero;
  logic [15:0] context_pointer;
  logic [15:0] stack_pointer;
  logic [15:0] stack_underflow_limit;
  logic [15:0] stack_overflow_limit;
  logic [15:0] serial_control;
  logic [15:0] serial_baud_reload;
  logic [15:0] can_status;
  logic [15:0] can_bit_timing;
  logic [15:0] periph_enable_reg;
  logic [15:0] load_count;
  logic [15:0] load_target;
  logic [7:0]  internal_ram [RAM_DEPTH];
  logic        ap_valid;
  logic        ap_write;
  logic [7:0]  ap_addr;
  logic [31:0] next_rdata;

  // reset configuration capture on the rising edge of the reset pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_pin_d <= 1'b0;
      latched   <= 1'b0;
      cfg       <= CFG_USER;
      ext_acc   <= 1'b1;
      bw8       <= 1'b0;
      bus_type_field      <= 2'h0;
    end else begin
      rst_pin_d <= reset_input_pin;
      if (reset_input_pin && !rst_pin_d && !latched) begin
        latched <= 1'b1;
        cfg     <= {boot_cfg_hi, boot_cfg_lo};
        ext_acc <= external_access_pin;
        bw8     <= bus_width_8;
        bus_type_field    <= bus_type_cfg;
      end
    end
  end

  // can glitch filter: level must hold 20 cycles to be accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_raw_d <= 1'b1;
      can_cnt   <= 5'h00;
      can_filt  <= 1'b1;
      ser_d     <= 1'b1;
    end else begin
      can_raw_d <= can_rx_line;
      ser_d     <= serial_rx_line;
      if (can_rx_line == can_filt) begin
        can_cnt <= 5'h00;
      end else if (can_cnt == 5'(CAN_FILT_CYC - 1)) begin
        can_filt <= can_rx_line;
        can_cnt  <= 5'h00;
      end else if (can_rx_line != can_raw_d) begin
        can_cnt <= 5'h01;
      end else begin
        can_cnt <= can_cnt + 5'h01;
      end
    end
  end

  // serial priority window from raw can falling edge to the next raw can rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      can_fall_seen <= 1'b0;
    end else if (state == BMSL_SCAN) begin
      if (!can_rx_line && can_raw_d) begin
        can_fall_seen <= 1'b1;
      end else if (can_rx_line) begin
        can_fall_seen <= 1'b0;
      end
    end
  end
  assign can_prio_ser = can_fall_seen;

  // boot sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= BMSL_WAIT;
      chan        <= BMSL_CH_NONE;
      start_addr  <= ADDR_ZERO;
      start_valid <= 1'b0;
      soft_reset  <= 1'b0;
      load_count  <= 16'h0000;
    end else begin
      soft_reset <= 1'b0;
      case (state)
        BMSL_WAIT: begin
          if (latched) begin
            state <= BMSL_DEC;
          end
        end
        BMSL_DEC: begin
          if (!cfg[0]) begin
            start_addr <= ADDR_TEST;
            state      <= BMSL_SCAN;
          end else if (cfg == CFG_USER) begin
            state <= BMSL_USER;
          end else if (user_sig_ok) begin
            state <= BMSL_USER;
          end else if (alt_sig_ok || user_key_alt) begin
            state <= BMSL_ALT;
          end else begin
            start_addr <= ADDR_TEST;
            state      <= BMSL_SCAN;
          end
        end
        BMSL_USER: begin
          soft_reset  <= 1'b1;
          start_addr  <= ADDR_ZERO;
          start_valid <= 1'b1;
          state       <= BMSL_RUN;
        end
        BMSL_ALT: begin
          start_addr  <= ADDR_ALT;
          start_valid <= 1'b1;
          state       <= BMSL_RUN;
        end
        BMSL_SCAN: begin
          if (!ser_d && (can_prio_ser || can_filt)) begin
            chan  <= BMSL_CH_SERIAL;
            state <= BMSL_LOAD;
          end else if (!can_filt && can_rx_line) begin
            chan  <= BMSL_CH_CAN;
            state <= BMSL_LOAD;
          end
        end
        BMSL_LOAD: begin
          if (rx_byte_valid) begin
            load_count <= load_count + 16'h0001;
            if (load_count + 16'h0001 >= load_target) begin
              start_addr  <= ADDR_ZERO;
              start_valid <= 1'b1;
              state       <= BMSL_RUN;
            end
          end
        end
        BMSL_RUN: begin
          state <= BMSL_RUN;
        end
        default: state <= BMSL_WAIT;
      endcase
    end
  end

  // downloaded bytes go into internal ram
  always_ff @(posedge hclk) begin
    if (state == BMSL_LOAD && rx_byte_valid) begin
      internal_ram[load_count[$clog2(RAM_DEPTH)-1:0]] <= rx_byte;
    end
  end

  // bootstrap core and peripheral configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_config_reg     <= ZERO16;
      bus_control_zero      <= ZERO16;
      context_pointer       <= ZERO16;
      stack_pointer         <= ZERO16;
      stack_underflow_limit <= ZERO16;
      stack_overflow_limit  <= ZERO16;
      serial_control        <= ZERO16;
      serial_baud_reload    <= ZERO16;
      can_status            <= ZERO16;
      can_bit_timing        <= ZERO16;
      periph_enable_reg     <= ZERO16;
    end else begin
      if (state == BMSL_SCAN || state == BMSL_ALT) begin
        context_pointer       <= CP_BOOT;
        stack_pointer         <= SP_BOOT;
        stack_underflow_limit <= STACK_UNDERFLOW_LIMIT_BOOT;
        stack_overflow_limit  <= STACK_OVERFLOW_LIMIT_BOOT;
        system_config_reg <= SYSCFG_BOOT;
        system_config_reg[SYS_EXT_PERIPH_ENABLE_BIT] <= (state == BMSL_ALT);
        system_config_reg[SYS_IMEN]     <= 1'b1;
        system_config_reg[SYS_BYTE_HIGH_DISABLE]   <= bw8;
        if (ext_acc) begin
          bus_control_zero <= ZERO16;
        end else begin
          bus_control_zero <= ZERO16;
          bus_control_zero[BUS_ACT_BIT] <= 1'b1;
          bus_control_zero[BUS_ALE_BIT] <= 1'b1;
          bus_control_zero[BUS_TYP_LO+1:BUS_TYP_LO] <= bus_type_field;
        end
      end
      if (state == BMSL_LOAD && chan == BMSL_CH_SERIAL) begin
        serial_control <= SERCTL_BOOT;
        if (baud_valid) begin
          serial_baud_reload <= baud_value;
        end
      end
      if (state == BMSL_LOAD && chan == BMSL_CH_CAN) begin
        system_config_reg[SYS_EXT_PERIPH_ENABLE_BIT] <= 1'b1;
        periph_enable_reg <= PERIPH_CAN;
        if (can_timing_valid) begin
          can_bit_timing <= can_timing_value;
        end else begin
          can_status <= ZERO16;
        end
      end
    end
  end

  // pin and mode outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_tx_line    <= 1'b1;
      serial_tx_oe      <= 1'b0;
      can_tx_line       <= 1'b1;
      can_tx_oe         <= 1'b0;
      watchdog_disable  <= 1'b0;
      bootstrap_mode    <= 1'b0;
      test_flash_fetch  <= 1'b0;
      flash_fetch_block <= 1'b0;
      cfg_reserved      <= 1'b0;
    end else begin
      serial_tx_line    <= 1'b1;
      can_tx_line       <= 1'b1;
      serial_tx_oe      <= (chan == BMSL_CH_SERIAL);
      can_tx_oe         <= (chan == BMSL_CH_CAN);
      bootstrap_mode    <= latched && !cfg[0];
      watchdog_disable  <= latched && !cfg[0];
      test_flash_fetch  <= latched && cfg == CFG_STD_BOOT && fetch_valid;
      flash_fetch_block <= latched && !cfg[0] && fetch_valid && fetch_from_flash;
      cfg_reserved      <= latched && cfg == 2'h0;
    end
  end

  // ahb-lite slave, zero wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
    end else if (hready) begin
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      load_target <= LOADCNT_RST;
    end else if (ap_valid && ap_write && ap_addr == OFS_LOADCNT) begin
      load_target <= hwdata[15:0];
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (haddr[7:0] == OFS_STATUS) begin
      next_rdata = {8'h00, internal_ram[0], load_count};
    end else if (haddr[7:0] == OFS_START) begin
      next_rdata = {7'h00, start_valid, start_addr};
    end else if (haddr[7:0] == OFS_SYSCFG) begin
      next_rdata = {16'h0000, system_config_reg};
    end else if (haddr[7:0] == OFS_BUSCTL) begin
      next_rdata = {16'h0000, bus_control_zero};
    end else if (haddr[7:0] == OFS_STACK) begin
      next_rdata = {stack_pointer, context_pointer};
    end else if (haddr[7:0] == OFS_LIMITS) begin
      next_rdata = {stack_overflow_limit, stack_underflow_limit};
    end else if (haddr[7:0] == OFS_SERIAL) begin
      next_rdata = {serial_baud_reload, serial_control};
    end else if (haddr[7:0] == OFS_PERIPH) begin
      next_rdata = {periph_enable_reg, can_status | can_bit_timing};
    end else if (haddr[7:0] == OFS_CONTROL) begin
      next_rdata = {16'h0000, 7'h00, state, chan};
    end else if (haddr[7:0] == OFS_LOADCNT) begin
      next_rdata = {16'h0000, load_target};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule

// >>> core/bmsl_pkg.sv
package bmsl_pkg;
  // boot configuration codes {boot_cfg_hi, boot_cfg_lo}
  localparam logic [1:0]  CFG_USER      = 2'h3;
  localparam logic [1:0]  CFG_STD_BOOT  = 2'h2;
  localparam logic [1:0]  CFG_ALT_BOOT  = 2'h1;
  // start addresses
  localparam logic [23:0] ADDR_ZERO     = 24'h000000;
  localparam logic [23:0] ADDR_ALT      = 24'h090000;
  localparam logic [23:0] ADDR_TEST     = 24'h000000;
  // bootstrap core setup values
  localparam logic [15:0] CP_BOOT       = 16'hFA00;
  localparam logic [15:0] SP_BOOT       = 16'hFA40;
  localparam logic [15:0] STACK_UNDERFLOW_LIMIT_BOOT    = 16'hFC00;
  localparam logic [15:0] STACK_OVERFLOW_LIMIT_BOOT    = 16'hFA00;
  localparam logic [15:0] SYSCFG_BOOT   = 16'h0404;
  localparam logic [15:0] SERCTL_BOOT   = 16'h8011;
  localparam logic [15:0] PERIPH_CAN    = 16'h042D;
  localparam logic [15:0] ZERO16        = 16'h0000;
  // field positions
  localparam int          SYS_EXT_PERIPH_ENABLE_BIT  = 2;
  localparam int          SYS_BYTE_HIGH_DISABLE    = 9;
  localparam int          SYS_IMEN      = 10;
  localparam int          BUS_ACT_BIT   = 10;
  localparam int          BUS_ALE_BIT   = 9;
  localparam int          BUS_TYP_LO    = 6;
  // can glitch filter, in cpu cycles
  localparam int          CAN_FILT_CYC  = 20;
  // register bus map
  localparam logic [7:0]  OFS_STATUS    = 8'h00;
  localparam logic [7:0]  OFS_START     = 8'h04;
  localparam logic [7:0]  OFS_SYSCFG    = 8'h08;
  localparam logic [7:0]  OFS_BUSCTL    = 8'h0C;
  localparam logic [7:0]  OFS_STACK     = 8'h10;
  localparam logic [7:0]  OFS_LIMITS    = 8'h14;
  localparam logic [7:0]  OFS_SERIAL    = 8'h18;
  localparam logic [7:0]  OFS_PERIPH    = 8'h1C;
  localparam logic [7:0]  OFS_CONTROL   = 8'h20;
  localparam logic [7:0]  OFS_LOADCNT   = 8'h24;
  localparam logic [15:0] LOADCNT_RST   = 16'h0020;

  typedef enum logic [6:0] {
    BMSL_WAIT  = 7'h01,
    BMSL_DEC   = 7'h02,
    BMSL_USER  = 7'h04,
    BMSL_ALT   = 7'h08,
    BMSL_SCAN  = 7'h10,
    BMSL_LOAD  = 7'h20,
    BMSL_RUN   = 7'h40
  } bmsl_state_t;

  typedef enum logic [1:0] {
    BMSL_CH_NONE   = 2'h0,
    BMSL_CH_SERIAL = 2'h1,
    BMSL_CH_CAN    = 2'h2
  } bmsl_chan_t;
endpackage

// >>> verif/bmsl_loader_properties.sv
`timescale 1ns/1ns
module bmsl_loader_chk
  import bmsl_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        reset_input_pin,
  input wire logic        boot_cfg_lo,
  input wire logic        boot_cfg_hi,
  input wire logic        user_sig_ok,
  input wire logic        alt_sig_ok,
  input wire logic        can_rx_line,
  input wire logic        fetch_valid,
  input wire logic        fetch_from_flash,
  input wire logic        serial_tx_line,
  input wire logic        serial_tx_oe,
  input wire logic        can_tx_line,
  input wire logic        can_tx_oe,
  input wire logic        watchdog_disable,
  input wire logic        bootstrap_mode,
  input wire logic        soft_reset,
  input wire logic        test_flash_fetch,
  input wire logic        flash_fetch_block,
  input wire logic [23:0] start_addr,
  input wire logic        start_valid,
  input wire logic        cfg_reserved
);
  logic       rip_q;
  logic       lat_done;
  logic [1:0] cfg_q;
  logic [4:0] low_run;
  logic       can_long;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // config seen at the first rise of the reset pin, and run of can dominant level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rip_q <= 1'b0;
      lat_done <= 1'b0;
      cfg_q <= 2'h0;
      low_run <= 5'h00;
      can_long <= 1'b0;
    end else begin
      rip_q <= reset_input_pin;
      if (reset_input_pin && !rip_q && !lat_done) begin
        lat_done <= 1'b1;
        cfg_q <= {boot_cfg_hi, boot_cfg_lo};
      end
      if (can_rx_line) low_run <= 5'h00;
      else if (low_run != 5'h1F) low_run <= low_run + 5'h01;
      if (!can_rx_line && low_run == 5'(CAN_FILT_CYC - 1)) can_long <= 1'b1;
    end
  end
  wdog_off_a: assert property (lat_done |=> watchdog_disable == !cfg_q[0])
    else $error("watchdog state wrong for boot mode");
  boot_entry_a: assert property ($rose(lat_done) && !cfg_q[0] |-> ##[1:8] bootstrap_mode)
    else $error("bootstrap not entered");
  user_noboot_a: assert property (lat_done && cfg_q[0] |-> !bootstrap_mode)
    else $error("bootstrap with cfg low bit set");
  tx_high_a: assert property ((serial_tx_oe |-> serial_tx_line) and
    (can_tx_oe |-> can_tx_line)) else $error("driven tx line not high");
  one_chan_a: assert property (serial_tx_oe |-> !can_tx_oe)
    else $error("both channels chosen");
  chan_hold_a: assert property (serial_tx_oe || can_tx_oe
    |=> $stable({serial_tx_oe, can_tx_oe})) else $error("channel choice changed");
  can_filt_a: assert property ($rose(can_tx_oe) |-> can_long)
    else $error("can accepted on short pulse");
  user_addr_a: assert property (start_valid && cfg_q == CFG_USER
    |-> start_addr == ADDR_ZERO) else $error("user start address wrong");
  alt_addr_a: assert property (start_valid && cfg_q == CFG_ALT_BOOT && !user_sig_ok
    && alt_sig_ok |-> start_addr == ADDR_ALT) else $error("alternate start address wrong");
  srst_pulse_a: assert property (soft_reset |-> cfg_q != CFG_STD_BOOT ##1 !soft_reset)
    else $error("bad soft reset pulse");
  flash_blk_a: assert property (bootstrap_mode && fetch_valid && fetch_from_flash
    |=> flash_fetch_block) else $error("flash fetch not blocked");
  test_fetch_a: assert property (bootstrap_mode && cfg_q == CFG_STD_BOOT && fetch_valid
    |=> test_flash_fetch) else $error("fetch not sent to test flash");
  rsvd_cfg_a: assert property ($rose(lat_done) && cfg_q == 2'h0 |-> ##[1:8] cfg_reserved)
    else $error("reserved code not flagged");
  cover property ($rose(serial_tx_oe));
  cover property ($rose(can_tx_oe));
  cover property (soft_reset);
endmodule
bind bmsl_loader bmsl_loader_chk u_chk (.hclk, .hresetn, .reset_input_pin, .boot_cfg_lo,
  .boot_cfg_hi, .user_sig_ok, .alt_sig_ok, .can_rx_line, .fetch_valid, .fetch_from_flash,
  .serial_tx_line, .serial_tx_oe, .can_tx_line, .can_tx_oe, .watchdog_disable, .bootstrap_mode,
  .soft_reset, .test_flash_fetch, .flash_fetch_block, .start_addr, .start_valid, .cfg_reserved);

// >>> verif/bmsl_host_model.sv
`timescale 1ns/1ns
module bmsl_host_model
  import bmsl_pkg::*;
#(
  parameter logic [15:0] BAUD       = 16'h0033,
  parameter logic [15:0] CAN_TIMING = 16'h0123
) (
  input  wire logic        hclk,
  output logic             serial_rx_line,
  output logic             can_rx_line,
  output logic             rx_byte_valid,
  output logic [7:0]       rx_byte,
  output logic             baud_valid,
  output logic [15:0]      baud_value,
  output logic             can_timing_valid,
  output logic [15:0]      can_timing_value
);
  initial begin
    serial_rx_line = 1'b1;
    can_rx_line = 1'b1;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h00;
    baud_valid = 1'b0;
    baud_value = ~BAUD;
    can_timing_valid = 1'b0;
    can_timing_value = ~CAN_TIMING;
  end
  // start bit, then the zero byte that yields the baud reload
  task automatic serial_start();
    serial_rx_line <= 1'b0;
    repeat (9) @(posedge hclk);
    serial_rx_line <= 1'b1;
    baud_valid <= 1'b1;
    baud_value <= BAUD;
    @(posedge hclk);
    baud_valid <= 1'b0;
    baud_value <= ~BAUD;
    @(posedge hclk);
  endtask
  // dominant level for n cycles; timing reported only for n of at least CAN_FILT_CYC
  task automatic can_low(input int n);
    can_rx_line <= 1'b0;
    repeat (n) @(posedge hclk);
    can_rx_line <= 1'b1;
    @(posedge hclk);
    can_timing_valid <= (n >= CAN_FILT_CYC);
    can_timing_value <= CAN_TIMING;
    @(posedge hclk);
    can_timing_valid <= 1'b0;
    can_timing_value <= ~CAN_TIMING;
    @(posedge hclk);
  endtask
  task automatic send_bytes(input int n);
    for (int i = 0; i < n; i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= 8'(i + 1);
      @(posedge hclk);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~8'(i + 1);
      @(posedge hclk);
    end
  endtask
endmodule

// >>> verif/bmsl_loader_tb_top.sv
`timescale 1ns/1ns
module bmsl_loader_tb_top
  import bmsl_pkg::*;
;
  localparam logic [15:0] BAUD = 16'h0033;
  localparam logic [15:0] CAN_TIME = 16'h0123;
  logic        hclk = 1'b0;
  logic        hresetn, reset_input_pin, boot_cfg_lo, boot_cfg_hi, external_access_pin;
  logic        bus_width_8, user_sig_ok, alt_sig_ok, user_key_alt, serial_rx_line;
  logic        can_rx_line, rx_byte_valid, baud_valid, can_timing_valid, fetch_valid;
  logic        fetch_from_flash, hsel, hwrite, hready, hreadyout, hresp;
  logic        serial_tx_line, serial_tx_oe, can_tx_line, can_tx_oe, watchdog_disable;
  logic        bootstrap_mode, soft_reset, test_flash_fetch, flash_fetch_block;
  logic        start_valid, cfg_reserved;
  logic [1:0]  bus_type_cfg, htrans;
  logic [2:0]  hsize;
  logic [7:0]  rx_byte;
  logic [15:0] baud_value, can_timing_value;
  logic [23:0] start_addr;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          mismatches = 0;
  int          num_checks = 0;
  int          srst_seen = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  always @(posedge hclk) if (soft_reset === 1'b1) srst_seen++;
  bmsl_loader DUT (.*);
  bmsl_host_model #(.BAUD(BAUD), .CAN_TIMING(CAN_TIME)) host (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string w);
    bus(1'b0, a, 32'h00000000);
    chk(rd & m, e, w);
    chk(hresp, 32'h0, "bus response");
  endtask
  task automatic boot(input logic [1:0] cfg, input logic ea, input logic w8,
                      input logic [2:0] sig);
    hresetn <= 1'b0;
    reset_input_pin <= 1'b0;
    {boot_cfg_hi, boot_cfg_lo} <= cfg;
    external_access_pin <= ea;
    bus_width_8 <= w8;
    bus_type_cfg <= 2'h2;
    {user_sig_ok, alt_sig_ok, user_key_alt} <= sig;
    repeat (16) @(posedge hclk);
    srst_seen = 0;
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    reset_input_pin <= 1'b1;
    repeat (12) @(posedge hclk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    finish_test();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    fetch_valid = 1'b0;
    fetch_from_flash = 1'b0;
    boot(CFG_USER, 1'b1, 1'b0, 3'h0);
    chk(start_valid, 32'h1, "user start valid");
    chk(start_addr, ADDR_ZERO, "user start address");
    chk(srst_seen, 32'h1, "user soft reset");
    chk(bootstrap_mode, 32'h0, "user not bootstrap");
    // user signature, alternate signature, user key alone
    for (int i = 0; i < 3; i++) begin
      boot(CFG_ALT_BOOT, 1'b1, 1'b0, 3'h4 >> i);
      chk(start_addr, (i == 0) ? ADDR_ZERO : ADDR_ALT, "alternate start");
      chk(srst_seen, (i == 0) ? 32'h1 : 32'h0, "alternate soft reset");
    end
    rchk(OFS_SYSCFG, 32'h00000404, 32'h00000404, "alternate sysconfig");
    boot(2'h0, 1'b1, 1'b0, 3'h0);
    chk(cfg_reserved, 32'h1, "reserved code");
    // serial boot while can has just fallen
    boot(CFG_STD_BOOT, 1'b0, 1'b1, 3'h0);
    chk(bootstrap_mode, 32'h1, "bootstrap entry");
    chk(watchdog_disable, 32'h1, "watchdog off");
    rchk(OFS_LOADCNT, 32'h0000FFFF, {16'h0000, LOADCNT_RST}, "load target reset");
    fetch_valid <= 1'b1;
    fetch_from_flash <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(flash_fetch_block, 32'h1, "flash fetch blocked");
    chk(test_flash_fetch, 32'h1, "test flash fetch");
    fetch_valid <= 1'b0;
    fork
      host.can_low(40);
      begin repeat (3) @(posedge hclk); host.serial_start(); end
    join
    repeat (40) @(posedge hclk);
    chk(serial_tx_oe, 32'h1, "serial chosen");
    chk(can_tx_oe, 32'h0, "can ignored");
    rchk(OFS_STACK, '1, {SP_BOOT, CP_BOOT}, "pointers");
    rchk(OFS_LIMITS, '1, {STACK_OVERFLOW_LIMIT_BOOT, STACK_UNDERFLOW_LIMIT_BOOT}, "stack limits");
    rchk(OFS_SERIAL, '1, {BAUD, SERCTL_BOOT}, "serial setup");
    rchk(OFS_BUSCTL, '1, 32'h00000680, "bus control bus on");
    bus(1'b1, OFS_SYSCFG, 32'hFFFFFFFF);
    rchk(OFS_SYSCFG, 32'h00000604, 32'h00000600, "serial sysconfig");
    rchk(8'h30, '1, 32'h00000000, "unmapped read");
    bus(1'b1, OFS_LOADCNT, 32'h00000004);
    host.send_bytes(4);
    repeat (4) @(posedge hclk);
    rchk(OFS_STATUS, 32'h00FFFFFF, 32'h00010004, "bytes loaded");
    // can boot: pulse one cycle short of the filter, then a valid one
    boot(CFG_STD_BOOT, 1'b1, 1'b0, 3'h0);
    host.can_low(CAN_FILT_CYC - 1);
    repeat (30) @(posedge hclk);
    chk(can_tx_oe, 32'h0, "short can pulse");
    host.can_low(30);
    repeat (30) @(posedge hclk);
    chk(can_tx_oe, 32'h1, "can chosen");
    host.serial_start();
    repeat (20) @(posedge hclk);
    chk(serial_tx_oe, 32'h0, "serial ignored");
    rchk(OFS_PERIPH, '1, {PERIPH_CAN, CAN_TIME}, "periph enable");
    rchk(OFS_SYSCFG, 32'h00000604, 32'h00000404, "can sysconfig");
    rchk(OFS_BUSCTL, '1, 32'h00000000, "bus control off");
    finish_test();
  end
endmodule
